/* File: rmsp_pkg.sv */
// Purpose: Shared constants and types for the reset and mode-select pin block.
// Assumes: 25 MHz bus clock, 32-bit Avalon-MM register port with byte addresses.
// Notes:   Offsets are byte addresses of aligned words.
package rmsp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [3:0] RMSP_OFS_SYS_OPTION  = 4'h0;
    localparam logic [3:0] RMSP_OFS_RESET_CAUSE = 4'h4;
    localparam logic [3:0] RMSP_OFS_DBG_FORCE   = 4'h8;
    localparam logic [3:0] RMSP_OFS_MODE_STATUS = 4'hC;

    // System option register fields
    localparam int RMSP_BIT_RST_PIN_EN  = 0;
    localparam int RMSP_BIT_DBG_PIN_EN  = 1;
    localparam int RMSP_BIT_LCD_EN      = 2;
    localparam int RMSP_BIT_CLK_INTERN  = 3;

    // Debug force reset register field
    localparam int RMSP_BIT_DBG_FORCE   = 0;

    // Mode status register fields
    localparam int RMSP_BIT_BDM_ACTIVE  = 0;
    localparam int RMSP_BIT_IN_RESET    = 1;

    // Reset cause bits
    localparam int RMSP_CAUSE_W         = 8;
    localparam int RMSP_CAUSE_POR       = 7;
    localparam int RMSP_CAUSE_PIN       = 6;
    localparam int RMSP_CAUSE_WDOG      = 5;
    localparam int RMSP_CAUSE_ILL_OP    = 4;
    localparam int RMSP_CAUSE_ILL_ADR   = 3;
    localparam int RMSP_CAUSE_LVD       = 1;
    localparam int RMSP_CAUSE_DBG_FORCE = 0;
    localparam int RMSP_CAUSE_STOP2     = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [RMSP_CAUSE_W-1:0] RMSP_CAUSE_RESET = 8'h80;
    localparam logic                    RMSP_RST_PIN_EN_RESET = 1'b1;
    localparam logic                    RMSP_DBG_PIN_EN_RESET = 1'b1;
    localparam logic                    RMSP_LCD_EN_RESET     = 1'b0;
    localparam logic                    RMSP_CLK_INTERN_RESET = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counts
    localparam int RMSP_PIN_LOW_CYCLES  = 34;
    localparam int RMSP_SETTLE_CYCLES   = 4;
    localparam int RMSP_BIT_DBG_CLKS    = 16;
    localparam int RMSP_TX_ONE_LOW      = 4;
    localparam int RMSP_TX_ZERO_LOW     = 13;
    localparam int RMSP_RX_SAMPLE       = 10;
    localparam int RMSP_CNT_W           = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic wdog;
        logic ill_op;
        logic ill_adr;
        logic low_voltage_detect;
        logic stop2_wake;
    } rmsp_rst_src_t;

    typedef struct packed {
        logic [3:0]  address;
        logic [3:0]  byteenable;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } rmsp_avs_req_t;

    typedef enum logic [2:0] {
        RMSP_ST_POR,
        RMSP_ST_RUN,
        RMSP_ST_ASSERT,
        RMSP_ST_SETTLE
    } rmsp_rst_state_t;

    typedef enum logic [1:0] {
        RMSP_DB_IDLE,
        RMSP_DB_TX,
        RMSP_DB_RX
    } rmsp_dbg_state_t;

endpackage : rmsp_pkg

/* File: rmsp_top.sv */
// Purpose: Reset pin, reset cause, mode-select sampling, debug pin timing, LCD pin state.
// Assumes: One 25 MHz clock; pins pass two flops; same-clock reset sources arrive raw.
// Notes:   i_rst_b is the power-on reset; all other resets are sequenced here.
`timescale 1ns/1ns
module rmsp_top #(
    parameter int LCD_PINS      = 32,
    parameter int LCD_GPIO_PINS = 18
) (
    // Clock and power-on reset
    input  wire logic                         i_clk,
    input  wire logic                         i_rst_b,
    // Avalon-MM slave
    input  wire rmsp_pkg::rmsp_avs_req_t      i_avs_req,
    output logic [31:0]                       o_avs_readdata,
    output logic                              o_avs_waitrequest,
    // Same-clock reset sources
    input  wire rmsp_pkg::rmsp_rst_src_t      i_rst_src,
    // Shared port/reset pin
    input  wire logic                         i_rst_pin_in,
    output logic                              o_rst_pin_out,
    output logic                              o_rst_pin_oe,
    output logic                              o_rst_pin_pullup,
    input  wire logic                         i_port_b_pin_two_data,
    // Shared background/mode-select pin
    input  wire logic                         i_background_pin_pin_in,
    output logic                              o_background_pin_pin_out,
    output logic                              o_background_pin_pin_oe,
    output logic                              o_background_pin_pullup,
    input  wire logic                         i_port_c_pin_six_data,
    input  wire logic                         i_port_c_pin_six_dir,
    // Background debug controller bit port
    input  wire logic                         i_dbg_clk_en,
    input  wire logic                         i_dbg_tx_valid,
    input  wire logic                         i_dbg_tx_bit,
    output logic                              o_dbg_tx_ready,
    output logic                              o_dbg_rx_valid,
    output logic                              o_dbg_rx_bit,
    // System controls
    output logic                              o_sys_rst_b,
    output logic                              o_bdm_active,
    output logic                              o_clk_internal,
    // LCD pins
    output logic [LCD_PINS-1:0]               o_lcd_seg_oe,
    output logic [LCD_GPIO_PINS-1:0]          o_lcd_gpio_mode
);
    import rmsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic rst_pin_s1_q, rst_pin_s2_q;
    logic background_pin_s1_q, background_pin_s2_q, background_pin_s3_q;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_pin_s1_q <= 1'b1;
            rst_pin_s2_q <= 1'b1;
            background_pin_s1_q    <= 1'b1;
            background_pin_s2_q    <= 1'b1;
            background_pin_s3_q    <= 1'b1;
        end else begin
            rst_pin_s1_q <= i_rst_pin_in;
            rst_pin_s2_q <= rst_pin_s1_q;
            background_pin_s1_q    <= i_background_pin_pin_in;
            background_pin_s2_q    <= background_pin_s1_q;
            background_pin_s3_q    <= background_pin_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM handshake: one wait cycle per access
    logic ack_q;
    logic access;
    logic wr_en;
    logic [31:0] rdata_q;

    assign access            = i_avs_req.read | i_avs_req.write;
    assign o_avs_waitrequest = access & ~ack_q;
    assign wr_en             = i_avs_req.write & ack_q & i_avs_req.byteenable[0];

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access & ~ack_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencer
    rmsp_rst_state_t         st_q;
    logic [RMSP_CNT_W-1:0]   rcnt_q;
    logic [RMSP_CAUSE_W-1:0] cause_q;
    logic                    rst_pin_en_q;
    logic                    dbg_pin_en_q;
    logic                    lcd_en_q;
    logic                    clk_intern_q;
    logic                    bdm_q;
    logic                    force_pending_q;
    logic                    keep_lcd_q;
    logic                    pin_drive_q;
    logic                    pin_req;
    logic                    force_req;
    logic                    any_req;
    logic [RMSP_CAUSE_W-1:0] new_cause;

    // Pin only counts as a reset request while its reset function is on
    assign pin_req   = rst_pin_en_q & ~rst_pin_s2_q;
    assign force_req = wr_en && i_avs_req.address == RMSP_OFS_DBG_FORCE
                       && i_avs_req.writedata[RMSP_BIT_DBG_FORCE];
    assign any_req   = pin_req | force_req | i_rst_src.wdog | i_rst_src.ill_op
                       | i_rst_src.ill_adr | i_rst_src.low_voltage_detect | i_rst_src.stop2_wake;

    always_comb begin
        new_cause                       = '0;
        new_cause[RMSP_CAUSE_PIN]       = pin_req;
        new_cause[RMSP_CAUSE_WDOG]      = i_rst_src.wdog;
        new_cause[RMSP_CAUSE_ILL_OP]    = i_rst_src.ill_op;
        new_cause[RMSP_CAUSE_ILL_ADR]   = i_rst_src.ill_adr;
        new_cause[RMSP_CAUSE_LVD]       = i_rst_src.low_voltage_detect;
        new_cause[RMSP_CAUSE_STOP2]     = i_rst_src.stop2_wake;
        new_cause[RMSP_CAUSE_DBG_FORCE] = force_req;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q   <= RMSP_ST_POR;
            rcnt_q <= '0;
        end else begin
            case (st_q)
                RMSP_ST_POR: begin
                    // Hold until the pin synchroniser has refilled after its reset value
                    if (rcnt_q == RMSP_CNT_W'(RMSP_SETTLE_CYCLES - 1)) begin
                        st_q <= RMSP_ST_RUN;
                    end else begin
                        rcnt_q <= rcnt_q + 1'b1;
                    end
                end
                RMSP_ST_RUN: begin
                    if (any_req) begin
                        st_q   <= RMSP_ST_ASSERT;
                        rcnt_q <= '0;
                    end
                end
                RMSP_ST_ASSERT: begin
                    if (rcnt_q == RMSP_CNT_W'(RMSP_PIN_LOW_CYCLES - 1)) begin
                        st_q   <= RMSP_ST_SETTLE;
                        rcnt_q <= '0;
                    end else begin
                        rcnt_q <= rcnt_q + 1'b1;
                    end
                end
                RMSP_ST_SETTLE: begin
                    // Pin needs time to rise through the pull-up and synchroniser
                    if (rcnt_q == RMSP_CNT_W'(RMSP_SETTLE_CYCLES - 1)) begin
                        st_q <= RMSP_ST_RUN;
                    end else begin
                        rcnt_q <= rcnt_q + 1'b1;
                    end
                end
                default: begin
                    st_q <= RMSP_ST_RUN;
                end
            endcase
        end
    end

    // Cause capture and held-through-reset context
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cause_q         <= RMSP_CAUSE_RESET;
            force_pending_q <= 1'b0;
            keep_lcd_q      <= 1'b0;
        end else if (st_q == RMSP_ST_RUN && any_req) begin
            cause_q         <= new_cause;
            force_pending_q <= force_req;
            keep_lcd_q      <= i_rst_src.stop2_wake;
        end
    end

    // Drive the reset pin low for the assert phase when it is enabled
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_drive_q <= 1'b0;
        end else begin
            pin_drive_q <= (st_q == RMSP_ST_RUN && any_req)
                           || (st_q == RMSP_ST_ASSERT
                               && rcnt_q != RMSP_CNT_W'(RMSP_PIN_LOW_CYCLES - 1));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Option bits
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_pin_en_q <= RMSP_RST_PIN_EN_RESET;
            dbg_pin_en_q <= RMSP_DBG_PIN_EN_RESET;
            lcd_en_q     <= RMSP_LCD_EN_RESET;
            clk_intern_q <= RMSP_CLK_INTERN_RESET;
        end else if (st_q == RMSP_ST_RUN && any_req) begin
            // Restore at the request so the pin gets its full low pulse
            if (i_rst_src.low_voltage_detect) begin
                rst_pin_en_q <= RMSP_RST_PIN_EN_RESET;
            end
        end else if (st_q == RMSP_ST_ASSERT) begin
            dbg_pin_en_q <= RMSP_DBG_PIN_EN_RESET;
            clk_intern_q <= RMSP_CLK_INTERN_RESET;
            if (!keep_lcd_q) begin
                lcd_en_q <= RMSP_LCD_EN_RESET;
            end
        end else if (wr_en && i_avs_req.address == RMSP_OFS_SYS_OPTION) begin
            // Reset function can only be given up; restore needs POR or LOW_VOLTAGE_DETECT
            if (!i_avs_req.writedata[RMSP_BIT_RST_PIN_EN]) begin
                rst_pin_en_q <= 1'b0;
            end
            dbg_pin_en_q <= i_avs_req.writedata[RMSP_BIT_DBG_PIN_EN];
            lcd_en_q     <= i_avs_req.writedata[RMSP_BIT_LCD_EN];
            clk_intern_q <= i_avs_req.writedata[RMSP_BIT_CLK_INTERN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode select: sampled on release of power-on or debug-forced reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bdm_q <= 1'b0;
        end else if (st_q == RMSP_ST_POR
                     && rcnt_q == RMSP_CNT_W'(RMSP_SETTLE_CYCLES - 1)) begin
            bdm_q <= ~background_pin_s2_q;
        end else if (st_q == RMSP_ST_SETTLE
                     && rcnt_q == RMSP_CNT_W'(RMSP_SETTLE_CYCLES - 1)) begin
            // Pin and other resets always come back in user mode
            bdm_q <= force_pending_q & ~background_pin_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Debug bit engine: 16 debug clocks per bit, pseudo open-drain
    rmsp_dbg_state_t       db_q;
    logic [4:0]            dcnt_q;
    logic                  tx_bit_q;
    logic                  dbg_drive_q;
    logic                  dbg_level_q;
    logic                  rx_valid_q;
    logic                  rx_bit_q;
    logic                  dbg_live;
    logic                  host_fall;

    // Engine owns the pin only when the background function is on and out of reset
    assign dbg_live       = dbg_pin_en_q & (st_q == RMSP_ST_RUN);
    assign host_fall      = background_pin_s3_q & ~background_pin_s2_q;
    assign o_dbg_tx_ready = dbg_live & (db_q == RMSP_DB_IDLE);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            db_q        <= RMSP_DB_IDLE;
            dcnt_q      <= '0;
            tx_bit_q    <= 1'b0;
            dbg_drive_q <= 1'b0;
            dbg_level_q <= 1'b1;
            rx_valid_q  <= 1'b0;
            rx_bit_q    <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            case (db_q)
                RMSP_DB_IDLE: begin
                    dcnt_q      <= '0;
                    dbg_drive_q <= 1'b0;
                    if (dbg_live && i_dbg_tx_valid) begin
                        db_q        <= RMSP_DB_TX;
                        tx_bit_q    <= i_dbg_tx_bit;
                        dbg_drive_q <= 1'b1;
                        dbg_level_q <= 1'b0;
                    end else if (dbg_live && host_fall) begin
                        db_q <= RMSP_DB_RX;
                    end
                end
                RMSP_DB_TX: begin
                    if (i_dbg_clk_en) begin
                        dcnt_q <= dcnt_q + 1'b1;
                        if (dcnt_q == 5'(RMSP_TX_ONE_LOW - 1) && tx_bit_q) begin
                            dbg_level_q <= 1'b1;
                        end else if (dcnt_q == 5'(RMSP_TX_ZERO_LOW - 1)) begin
                            dbg_level_q <= 1'b1;
                        end else if (dbg_level_q) begin
                            // Speedup pulse lasts one debug clock, then release
                            dbg_drive_q <= 1'b0;
                        end
                        if (dcnt_q == 5'(RMSP_BIT_DBG_CLKS - 1)) begin
                            db_q        <= RMSP_DB_IDLE;
                            dbg_drive_q <= 1'b0;
                        end
                    end
                end
                RMSP_DB_RX: begin
                    if (i_dbg_clk_en) begin
                        dcnt_q <= dcnt_q + 1'b1;
                        if (dcnt_q == 5'(RMSP_RX_SAMPLE - 1)) begin
                            rx_bit_q   <= background_pin_s2_q;
                            rx_valid_q <= 1'b1;
                        end
                        if (dcnt_q == 5'(RMSP_BIT_DBG_CLKS - 1)) begin
                            db_q <= RMSP_DB_IDLE;
                        end
                    end
                end
                default: begin
                    db_q <= RMSP_DB_IDLE;
                end
            endcase
            if (!dbg_live) begin
                db_q        <= RMSP_DB_IDLE;
                dbg_drive_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers, registered
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rst_pin_out    <= 1'b0;
            o_rst_pin_oe     <= 1'b0;
            o_background_pin_pin_out   <= 1'b1;
            o_background_pin_pin_oe    <= 1'b0;
            o_background_pin_pullup    <= 1'b1;
        end else begin
            // Open drain either way: only ever drives low
            o_rst_pin_out <= 1'b0;
            o_rst_pin_oe  <= rst_pin_en_q ? pin_drive_q
                                          : ~i_port_b_pin_two_data;
            if (dbg_pin_en_q) begin
                o_background_pin_pin_out <= dbg_level_q;
                o_background_pin_pin_oe  <= dbg_drive_q;
            end else begin
                o_background_pin_pin_out <= i_port_c_pin_six_data;
                o_background_pin_pin_oe  <= i_port_c_pin_six_dir;
            end
            o_background_pin_pullup <= dbg_pin_en_q;
        end
    end

    assign o_rst_pin_pullup = 1'b1;
    assign o_dbg_rx_valid   = rx_valid_q;
    assign o_dbg_rx_bit     = rx_bit_q;

    ////////////////////////////////////////////////////////////////////////////
    // System outputs and LCD pins
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_sys_rst_b     <= 1'b0;
            o_bdm_active    <= 1'b0;
            o_clk_internal  <= 1'b1;
            o_lcd_seg_oe    <= '0;
            o_lcd_gpio_mode <= '1;
        end else begin
            o_sys_rst_b     <= (st_q == RMSP_ST_RUN) && !any_req;
            o_bdm_active    <= bdm_q;
            o_clk_internal  <= clk_intern_q;
            o_lcd_seg_oe    <= {LCD_PINS{lcd_en_q}};
            o_lcd_gpio_mode <= {LCD_GPIO_PINS{~lcd_en_q}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_q <= '0;
        end else if (i_avs_req.read && !ack_q) begin
            rdata_q <= '0;
            case (i_avs_req.address)
                RMSP_OFS_SYS_OPTION: begin
                    rdata_q[RMSP_BIT_RST_PIN_EN] <= rst_pin_en_q;
                    rdata_q[RMSP_BIT_DBG_PIN_EN] <= dbg_pin_en_q;
                    rdata_q[RMSP_BIT_LCD_EN]     <= lcd_en_q;
                    rdata_q[RMSP_BIT_CLK_INTERN] <= clk_intern_q;
                end
                RMSP_OFS_RESET_CAUSE: begin
                    rdata_q[RMSP_CAUSE_W-1:0] <= cause_q;
                end
                RMSP_OFS_MODE_STATUS: begin
                    rdata_q[RMSP_BIT_BDM_ACTIVE] <= bdm_q;
                    rdata_q[RMSP_BIT_IN_RESET]   <= (st_q != RMSP_ST_RUN);
                end
                default: begin
                    rdata_q <= '0;
                end
            endcase
        end
    end

    assign o_avs_readdata = rdata_q;

endmodule : rmsp_top

/* File: rmsp_host.sv */
// Purpose: reset source and debug host. Assumes: pulled-up pins. Notes: wired low.
`timescale 1ns/1ns
module rmsp_host (
    // Host controls
    input  wire logic i_pull_rst,
    input  wire logic i_hold_ms,
    // Device drive
    input  wire logic i_rst_pin_oe,
    input  wire logic i_background_pin_pin_oe,
    input  wire logic i_background_pin_pin_out,
    // Pin levels
    output logic      o_rst_pin,
    output logic      o_background_pin_pin
);
    // Reset pin: pull-up wins unless some party pulls low; background pin: device drive wins over the host
    assign o_rst_pin  = !(i_rst_pin_oe || i_pull_rst);
    assign o_background_pin_pin = i_background_pin_pin_oe ? i_background_pin_pin_out : !i_hold_ms;
endmodule : rmsp_host

/* File: rmsp_checker.sv */
// Purpose: port checks. Assumes: one clock. Notes: bound to rmsp_top.
`timescale 1ns/1ns
module rmsp_checker (
    // Clock, reset, bus
    input wire logic                    i_clk,
    input wire logic                    i_rst_b,
    input wire rmsp_pkg::rmsp_avs_req_t i_avs_req,
    input wire logic                    o_avs_waitrequest,
    // Pins and controls
    input wire logic                    o_rst_pin_oe,
    input wire logic                    o_rst_pin_pullup,
    input wire logic                    o_background_pin_pullup,
    input wire logic                    o_sys_rst_b,
    input wire logic                    o_bdm_active,
    input wire logic                    o_clk_internal
);
    import rmsp_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // The drive is longer than a repetition may count, so a counter measures it
    int oe_run;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            oe_run <= 0;
        end else begin
            oe_run <= o_rst_pin_oe ? oe_run + 1 : 0;
        end
    end
    chk_oe_length: assert property ($fell(o_rst_pin_oe) |-> oe_run == RMSP_PIN_LOW_CYCLES)
        else $error("reset pin drive length wrong");
    chk_oe_settle: assert property ($rose(o_sys_rst_b) |-> $past(!o_rst_pin_oe, 3))
        else $error("pin still driven at release");
    chk_sys_span: assert property ($fell(o_sys_rst_b) |-> !o_sys_rst_b[*8] ##31
        !o_sys_rst_b ##1 o_sys_rst_b) else $error("system reset span wrong");
    chk_dbg_pull: assert property ($rose(o_sys_rst_b) |-> o_background_pin_pullup)
        else $error("debug pull-up off after reset");
    chk_clk_intern: assert property ($rose(o_sys_rst_b) |-> o_clk_internal)
        else $error("external clock after reset");
    chk_mode_release: assert property ($rose(o_bdm_active) |-> $past(!o_sys_rst_b))
        else $error("mode changed outside reset");
    chk_rst_pullup: assert property (o_rst_pin_pullup == 1'b1)
        else $error("reset pin pull-up off");
    chk_bus_wait: assert property ($rose(i_avs_req.read || i_avs_req.write)
        |-> o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("bus answer timing");
    cover property ($rose(o_rst_pin_oe));
    cover property ($rose(o_bdm_active));
    cover property ($fell(o_sys_rst_b));
endmodule : rmsp_checker
bind rmsp_top rmsp_checker u_rmsp_checker (.i_clk, .i_rst_b, .i_avs_req, .o_avs_waitrequest,
    .o_rst_pin_oe, .o_rst_pin_pullup, .o_background_pin_pullup, .o_sys_rst_b, .o_bdm_active,
    .o_clk_internal);

/* File: tb.sv */
// Purpose: bench for rmsp_top. Assumes: 25 MHz. Notes: bus tasks, host model.
`timescale 1ns/1ns
module tb;
    import rmsp_pkg::*;
    logic clk = 0, rst_b = 0, pull = 0, ms = 0, pb = 1, rp, bp, wr, boe, bout, roe, srb, background_debug_mode;
    logic txv = 0, txb = 0, trdy;
    logic [31:0] rd, q, seg;
    logic [17:0] gm;
    rmsp_avs_req_t req = '0;
    rmsp_rst_src_t src = '0;
    int err_total = 0, total_checks = 0;
    always #20 clk = ~clk;
    rmsp_top u_rmsp_top (.i_clk(clk), .i_rst_b(rst_b), .i_avs_req(req), .o_avs_readdata(rd),
        .o_avs_waitrequest(wr), .i_rst_src(src), .i_rst_pin_in(rp), .o_rst_pin_out(),
        .o_rst_pin_oe(roe), .o_rst_pin_pullup(), .i_port_b_pin_two_data(pb),
        .i_background_pin_pin_in(bp), .o_background_pin_pin_out(bout), .o_background_pin_pin_oe(boe), .o_background_pin_pullup(),
        .i_port_c_pin_six_data(1'b1), .i_port_c_pin_six_dir(1'b0), .i_dbg_clk_en(1'b1),
        .i_dbg_tx_valid(txv), .i_dbg_tx_bit(txb), .o_dbg_tx_ready(trdy), .o_dbg_rx_valid(),
        .o_dbg_rx_bit(), .o_sys_rst_b(srb), .o_bdm_active(background_debug_mode), .o_clk_internal(),
        .o_lcd_seg_oe(seg), .o_lcd_gpio_mode(gm));
    rmsp_host u_rmsp_host (.i_pull_rst(pull), .i_hold_ms(ms), .i_rst_pin_oe(roe),
        .i_background_pin_pin_oe(boe), .i_background_pin_pin_out(bout), .o_rst_pin(rp), .o_background_pin_pin(bp));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d);
        req <= '{a, 4'hF, !w, w, d};
        do @(posedge clk); while (wr !== 1'b0);
        q = rd;
        req <= '0;
        @(posedge clk);
    endtask : acc
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        acc(a, 1'b0, 32'h0);
        chk(q, e);
    endtask : rdc
    // Counts the cycles in which the device pulls the reset pin low
    task automatic trig(input logic p, input rmsp_rst_src_t s, input logic en, input logic f);
        int n, k;
        n = 0;
        k = 0;
        if (f) acc(RMSP_OFS_DBG_FORCE, 1'b1, 32'h1);
        else begin
            pull <= p;
            src <= s;
            repeat (2) @(posedge clk);
            pull <= 1'b0;
            src <= '0;
        end
        do begin @(negedge clk); n++; k += int'(roe); end while ((srb !== 1'b1 || n < 4) && n < 100);
        @(posedge clk);
        chk({31'h0, n < 100}, 32'h1);
        chk({31'h0, en ? (k > 32 && k < 36) : (k == 0)}, 32'h1);
    endtask : trig
    // One debug bit with the debug clock enabled every bus cycle
    task automatic dtx(input logic b, input int lo);
        int n, lw, hi;
        n = 0;
        lw = 0;
        hi = 0;
        txv <= 1'b1;
        txb <= b;
        do @(posedge clk); while (trdy !== 1'b1);
        txv <= 1'b0;
        do begin
            @(negedge clk);
            n++;
            lw += int'(boe & !bout);
            hi += int'(boe & bout);
        end while (trdy !== 1'b1 && n < 40);
        @(posedge clk);
        chk(32'(lw), 32'(lo));
        chk(32'(hi), 32'h1);
        chk(32'(n), 32'(RMSP_BIT_DBG_CLKS + 1));
    endtask : dtx
    task automatic end_sim;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    initial begin
        #400000;
        err_total++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rdc(RMSP_OFS_RESET_CAUSE, 32'h80);
        rdc(RMSP_OFS_SYS_OPTION, 32'hB);
        rdc(RMSP_OFS_MODE_STATUS, 32'h0);
        rdc(4'h2, 32'h0);
        chk(seg, 32'h0);
        chk(32'(gm), 32'h3FFFF);
        dtx(1'b1, RMSP_TX_ONE_LOW);
        dtx(1'b0, RMSP_TX_ZERO_LOW);
        acc(RMSP_OFS_SYS_OPTION, 1'b1, 32'hF);
        rdc(RMSP_OFS_SYS_OPTION, 32'hF);
        chk(seg, 32'hFFFFFFFF);
        trig(1'b0, 5'b10000, 1'b1, 1'b0);
        rdc(RMSP_OFS_RESET_CAUSE, 32'h20);
        rdc(RMSP_OFS_SYS_OPTION, 32'hB);
        acc(RMSP_OFS_SYS_OPTION, 1'b1, 32'hF);
        trig(1'b0, 5'b00001, 1'b1, 1'b0);
        rdc(RMSP_OFS_RESET_CAUSE, 32'h04);
        rdc(RMSP_OFS_SYS_OPTION, 32'hF);
        ms <= 1'b1;
        trig(1'b1, '0, 1'b1, 1'b0);
        rdc(RMSP_OFS_RESET_CAUSE, 32'h40);
        rdc(RMSP_OFS_MODE_STATUS, 32'h0);
        trig(1'b0, '0, 1'b1, 1'b1);
        rdc(RMSP_OFS_MODE_STATUS, 32'h1);
        rdc(RMSP_OFS_RESET_CAUSE, 32'h01);
        acc(RMSP_OFS_SYS_OPTION, 1'b1, 32'hA);
        trig(1'b0, 5'b10000, 1'b0, 1'b0);
        rdc(RMSP_OFS_SYS_OPTION, 32'hA);
        trig(1'b0, 5'b00010, 1'b1, 1'b0);
        rdc(RMSP_OFS_SYS_OPTION, 32'hB);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        // Sequencer holds its own reset until the mode pin has been sampled
        do @(posedge clk); while (srb !== 1'b1);
        rdc(RMSP_OFS_MODE_STATUS, 32'h1);
        chk({31'h0, background_debug_mode}, 32'h1);
        end_sim();
    end
endmodule : tb
